// ---- hw/tcic_top.sv ----
`timescale 1ns/100ps
`include "tcic_params.svh"
// Operation
// - Sixteen-bit up/down counter, counts or clears per tick
// - Clock select zero stops the counter
// - Processor reads and writes counter anytime
// - Processor write beats clear or count
// - Upper byte accesses hit shared latch
// - Low byte read loads latch with upper
// - Low byte write loads all sixteen bits
// - Four-bit mode field selects count sequence
// - Overflow flag set point depends on mode
// - Matching trigger edge copies counter into capture
// - Capture flag set in same cycle
// - Enabled flag interrupts; clears by service or one
// - Capture low read loads latch with upper
// - Capture writable only in capture-ceiling modes
// - Trigger is pin, or comparator when selected
// - Filter output changes after four agreeing samples
// - Filter enable adds four cycles delay
// - Filter samples on system clock
// - Detector active except in capture-ceiling modes
// - Each capture overwrites previous value
// - Pin driven by port output also triggers
// - Floor at zero, maximum is all ones
module tcic_top
    import tcic_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic [2:0] bus_addr,
    input  wire logic       bus_rd,
    input  wire logic       bus_wr,
    input  wire logic [7:0] bus_wdata,
    output logic      [7:0] bus_rdata,
    input  wire logic       capture_pin,
    input  wire logic       comparator_output,
    input  wire logic       comparator_capture_select,
    input  wire logic       external_count_pin,
    input  wire logic       capture_irq_enable,
    input  wire logic       overflow_irq_enable,
    input  wire logic       capture_irq_ack,
    input  wire logic       overflow_irq_ack,
    output logic            capture_irq,
    output logic            overflow_irq,
    output logic            count_floor,
    output logic     [15:0] counter_value,
    output logic     [15:0] capture_value
);
    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    logic [7:0] timer_control_a_q, timer_control_a_d;
    logic [7:0] timer_control_b_q, timer_control_b_d;
    logic [7:0] temp_q, temp_d;
    tcic_word_t cnt_q, cnt_d;
    tcic_word_t cap_q, cap_d;
    tcic_dir_e  dir_q, dir_d;
    logic       ovf_q, ovf_d;
    logic       capf_q, capf_d;
    logic [7:0] rdata_q, rdata_d;
    tcic_wgm_t  waveform_mode_field;
    logic       timer_tick;
    logic       cap_event;
    logic       cap_is_top;
    logic       dual_slope;
    logic       ovf_at_floor;
    tcic_word_t top_val;
    logic       at_top;
    logic       wr_cnt;

    assign waveform_mode_field = {timer_control_b_q[`TCIC_CTLB_WGM_LSB +: 2],
                                  timer_control_a_q[`TCIC_CTLA_WGM_LSB +: 2]};
    assign wr_cnt = bus_wr && (bus_addr == `TCIC_ADDR_CNT_LO);

    // ------------------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------------------
    tcic_tick_gen u_tick
    (
        .core_clk           (core_clk),
        .sys_rst            (sys_rst),
        .clock_select_field (timer_control_b_q[`TCIC_CTLB_CS_LSB +: 3]),
        .external_count_pin (external_count_pin),
        .timer_tick         (timer_tick)
    );

    // Pin level (whoever drives it, including the port output) feeds the detector.
    tcic_cap_filter u_filt
    (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .trig_in     (comparator_capture_select ? comparator_output
                                                : capture_pin),
        .filter_en   (timer_control_b_q[`TCIC_CTLB_FILT_BIT]),
        .edge_rising (timer_control_b_q[`TCIC_CTLB_EDGE_BIT]),
        .detect_en   (~cap_is_top),
        .cap_event   (cap_event)
    );

    // ------------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------------
    // Ceiling and slope per mode; modes outside the count sequence list run free.
    always_comb
    begin
        cap_is_top   = 1'b0;
        dual_slope   = 1'b0;
        ovf_at_floor = 1'b0;
        top_val      = `TCIC_CNT_MAX;
        case (waveform_mode_field)
            4'h1: begin top_val = `TCIC_TOP_8BIT;  dual_slope = 1'b1; end
            4'h2: begin top_val = `TCIC_TOP_9BIT;  dual_slope = 1'b1; end
            4'h3: begin top_val = `TCIC_TOP_10BIT; dual_slope = 1'b1; end
            4'h5: top_val = `TCIC_TOP_8BIT;
            4'h6: top_val = `TCIC_TOP_9BIT;
            4'h7: top_val = `TCIC_TOP_10BIT;
            4'h8:
            begin
                top_val      = cap_q;
                cap_is_top   = 1'b1;
                dual_slope   = 1'b1;
                ovf_at_floor = 1'b1;
            end
            4'ha: begin top_val = cap_q; cap_is_top = 1'b1; dual_slope = 1'b1; end
            4'hc: begin top_val = cap_q; cap_is_top = 1'b1; end
            4'he: begin top_val = cap_q; cap_is_top = 1'b1; end
            default: top_val = `TCIC_CNT_MAX;
        endcase
        if (dual_slope && !ovf_at_floor)
            ovf_at_floor = 1'b1;
    end

    assign at_top      = (cnt_q == top_val);
    assign count_floor = (cnt_q == `TCIC_CNT_FLOOR);

    // ------------------------------------------------------------------------
    // Counter, capture and flags
    // ------------------------------------------------------------------------
    // Bus write is evaluated last so it overrides any tick in the same cycle.
    always_comb
    begin
        cnt_d  = cnt_q;
        dir_d  = dir_q;
        ovf_d  = ovf_q;
        cap_d  = cap_q;
        capf_d = capf_q;
        temp_d = temp_q;
        timer_control_a_d = timer_control_a_q;
        timer_control_b_d = timer_control_b_q;
        // Software clears first so that a coinciding hardware set wins.
        if (bus_wr && bus_addr == `TCIC_ADDR_FLAGS)
        begin
            if (bus_wdata[`TCIC_FLAG_OVF_BIT])
                ovf_d = 1'b0;
            if (bus_wdata[`TCIC_FLAG_CAP_BIT])
                capf_d = 1'b0;
        end
        if (capture_irq_ack)
            capf_d = 1'b0;
        if (overflow_irq_ack)
            ovf_d = 1'b0;
        if (timer_tick)
        begin
            if (dual_slope)
            begin
                if (dir_q == TCIC_DIR_UP)
                begin
                    if (at_top)
                    begin
                        dir_d = TCIC_DIR_DOWN;
                        cnt_d = cnt_q - 16'h0001;
                    end
                    else
                        cnt_d = cnt_q + 16'h0001;
                end
                else if (count_floor)
                begin
                    dir_d = TCIC_DIR_UP;
                    cnt_d = cnt_q + 16'h0001;
                    ovf_d = ovf_d | ovf_at_floor;
                end
                else
                    cnt_d = cnt_q - 16'h0001;
            end
            else if (at_top)
            begin
                cnt_d = `TCIC_CNT_FLOOR;
                ovf_d = 1'b1;
            end
            else
                cnt_d = cnt_q + 16'h0001;
        end
        if (cap_event)
        begin
            cap_d  = cnt_q;
            capf_d = 1'b1;
        end
        if (bus_rd && bus_addr == `TCIC_ADDR_CNT_LO)
            temp_d = cnt_q[15:8];
        if (bus_rd && bus_addr == `TCIC_ADDR_CAP_LO)
            temp_d = cap_q[15:8];
        if (bus_wr)
        begin
            case (bus_addr)
                `TCIC_ADDR_CNT_HI: temp_d = bus_wdata;
                `TCIC_ADDR_CAP_HI: temp_d = bus_wdata;
                `TCIC_ADDR_CTRL_A: timer_control_a_d = bus_wdata;
                `TCIC_ADDR_CTRL_B: timer_control_b_d = bus_wdata;
                `TCIC_ADDR_CAP_LO:
                    if (cap_is_top)
                        cap_d = {temp_q, bus_wdata};
                default: temp_d = temp_d;
            endcase
        end
        if (wr_cnt)
            cnt_d = {temp_q, bus_wdata};
    end

    // Read mux; the upper-byte locations return the shared latch.
    always_comb
    begin
        case (bus_addr)
            `TCIC_ADDR_CNT_LO: rdata_d = cnt_q[7:0];
            `TCIC_ADDR_CNT_HI: rdata_d = temp_q;
            `TCIC_ADDR_CAP_LO: rdata_d = cap_q[7:0];
            `TCIC_ADDR_CAP_HI: rdata_d = temp_q;
            `TCIC_ADDR_CTRL_A: rdata_d = timer_control_a_q;
            `TCIC_ADDR_CTRL_B: rdata_d = timer_control_b_q;
            `TCIC_ADDR_FLAGS:
            begin
                rdata_d = 8'h00;
                rdata_d[`TCIC_FLAG_OVF_BIT] = ovf_q;
                rdata_d[`TCIC_FLAG_CAP_BIT] = capf_q;
            end
            default: rdata_d = 8'h00;
        endcase
        if (!bus_rd)
            rdata_d = rdata_q;
    end

    // Registers only.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            timer_control_a_q <= `TCIC_CTRL_RST;
            timer_control_b_q <= `TCIC_CTRL_RST;
            temp_q  <= 8'h00;
            cnt_q   <= `TCIC_CNT_FLOOR;
            cap_q   <= 16'h0000;
            dir_q   <= TCIC_DIR_UP;
            ovf_q   <= 1'b0;
            capf_q  <= 1'b0;
            rdata_q <= 8'h00;
        end
        else
        begin
            timer_control_a_q <= timer_control_a_d;
            timer_control_b_q <= timer_control_b_d;
            temp_q  <= temp_d;
            cnt_q   <= cnt_d;
            cap_q   <= cap_d;
            dir_q   <= dir_d;
            ovf_q   <= ovf_d;
            capf_q  <= capf_d;
            rdata_q <= rdata_d;
        end
    end

    assign bus_rdata     = rdata_q;
    assign counter_value = cnt_q;
    assign capture_value = cap_q;
    // Interrupt requests are level, gated by the enables.
    assign capture_irq   = capf_q & capture_irq_enable;
    assign overflow_irq  = ovf_q & overflow_irq_enable;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    property p_stopped;
        @(posedge core_clk) disable iff (sys_rst)
        (timer_control_b_q[2:0] == 3'h0 && $stable(timer_control_b_q) && !wr_cnt
         && !$past(wr_cnt)) |=> $stable(cnt_q);
    endproperty
    a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

    property p_wr_prio;
        @(posedge core_clk) disable iff (sys_rst)
        wr_cnt |=> cnt_q == {$past(temp_q), $past(bus_wdata)};
    endproperty
    a_wr_prio: assert property (p_wr_prio) else $error("counter write lost");

    property p_lo_rd;
        @(posedge core_clk) disable iff (sys_rst)
        (bus_rd && bus_addr == `TCIC_ADDR_CNT_LO && !bus_wr) |=> temp_q == $past(cnt_q[15:8]);
    endproperty
    a_lo_rd: assert property (p_lo_rd) else $error("latch not loaded on low read");

    property p_cap;
        @(posedge core_clk) disable iff (sys_rst)
        (cap_event && !(bus_wr && bus_addr == `TCIC_ADDR_CAP_LO))
        |=> cap_q == $past(cnt_q) && capf_q;
    endproperty
    a_cap: assert property (p_cap) else $error("capture or flag missing");

    property p_cap_rd;
        @(posedge core_clk) disable iff (sys_rst)
        (bus_rd && bus_addr == `TCIC_ADDR_CAP_LO && !bus_wr) |=> temp_q == $past(cap_q[15:8]);
    endproperty
    a_cap_rd: assert property (p_cap_rd) else $error("latch not loaded on capture read");

    property p_cap_wr;
        @(posedge core_clk) disable iff (sys_rst)
        (!cap_is_top && !cap_event) |=> $stable(cap_q);
    endproperty
    a_cap_wr: assert property (p_cap_wr) else $error("capture written in wrong mode");

    property p_irq;
        @(posedge core_clk) disable iff (sys_rst)
        capture_irq_ack && !cap_event |=> !capf_q;
    endproperty
    a_irq: assert property (p_irq) else $error("flag not cleared by service");

    property p_floor;
        @(posedge core_clk) disable iff (sys_rst)
        (waveform_mode_field == 4'h0 && timer_tick && !wr_cnt && cnt_q == `TCIC_CNT_MAX)
        |=> count_floor && ovf_q;
    endproperty
    a_floor: assert property (p_floor) else $error("floor wrong");

    property p_no_det;
        @(posedge core_clk) disable iff (sys_rst)
        (cap_is_top && !(bus_wr && bus_addr == `TCIC_ADDR_CAP_LO)) |=> $stable(cap_q);
    endproperty
    a_no_det: assert property (p_no_det) else $error("detector active in ceiling mode");

    c_cap:  cover property (@(posedge core_clk) cap_event);
    c_ovf:  cover property (@(posedge core_clk) $rose(ovf_q));
    c_down: cover property (@(posedge core_clk) dir_q == TCIC_DIR_DOWN);
endmodule

// ---- hw/tcic_params.svh ----
`ifndef TCIC_PARAMS_SVH
`define TCIC_PARAMS_SVH
// ----------------------------------------------------------------------------
// Byte addresses on the processor's 8-bit bus
// ----------------------------------------------------------------------------
`define TCIC_ADDR_CNT_LO   3'h0
`define TCIC_ADDR_CNT_HI   3'h1
`define TCIC_ADDR_CAP_LO   3'h2
`define TCIC_ADDR_CAP_HI   3'h3
`define TCIC_ADDR_CTRL_A   3'h4
`define TCIC_ADDR_CTRL_B   3'h5
`define TCIC_ADDR_FLAGS    3'h6
// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define TCIC_CTLA_WGM_LSB  0
`define TCIC_CTLB_CS_LSB   0
`define TCIC_CTLB_WGM_LSB  3
`define TCIC_CTLB_EDGE_BIT 6
`define TCIC_CTLB_FILT_BIT 7
`define TCIC_FLAG_OVF_BIT  0
`define TCIC_FLAG_CAP_BIT  5
`define TCIC_CTRL_RST      8'h00
`define TCIC_CNT_FLOOR     16'h0000
`define TCIC_CNT_MAX       16'hffff
`define TCIC_TOP_8BIT      16'h00ff
`define TCIC_TOP_9BIT      16'h01ff
`define TCIC_TOP_10BIT     16'h03ff
// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define TCIC_FILT_SAMPLES  4
`define TCIC_PRE_DIV_W     10
`endif

// ---- hw/tcic_pkg.sv ----
package tcic_pkg;
    // Counter direction while running in dual-slope modes.
    typedef enum logic {TCIC_DIR_UP, TCIC_DIR_DOWN} tcic_dir_e;
    typedef logic [15:0] tcic_word_t;
    typedef logic [3:0]  tcic_wgm_t;
endpackage

// ---- hw/tcic_tick_gen.sv ----
`timescale 1ns/100ps
`include "tcic_params.svh"
// ----------------------------------------------------------------------------
// Timer tick source: stopped, prescaled system clock or external pin edges
// ----------------------------------------------------------------------------
module tcic_tick_gen
    import tcic_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic [2:0] clock_select_field,
    input  wire logic       external_count_pin,
    output logic            timer_tick
);
    logic [`TCIC_PRE_DIV_W-1:0] pre_q, pre_d;
    logic [2:0]                 ext_q, ext_d;
    logic                       ext_lvl_q, ext_lvl_d;
    logic                       tick_d;

    // Free prescaler and three-stage pin sampler; level moves once stages 2 and 3 agree.
    always_comb
    begin
        pre_d     = pre_q + 1'b1;
        ext_d     = {ext_q[1:0], external_count_pin};
        ext_lvl_d = (ext_q[1] == ext_q[2]) ? ext_q[2] : ext_lvl_q;
        case (clock_select_field)
            3'h0: tick_d = 1'b0;                                  // Stopped.
            3'h1: tick_d = 1'b1;
            3'h2: tick_d = (pre_q[2:0] == 3'h7);
            3'h3: tick_d = (pre_q[5:0] == 6'h3f);
            3'h4: tick_d = (pre_q[7:0] == 8'hff);
            3'h5: tick_d = (pre_q == 10'h3ff);
            3'h6: tick_d = ext_lvl_q & ~ext_lvl_d;
            3'h7: tick_d = ~ext_lvl_q & ext_lvl_d;
            default: tick_d = 1'b0;
        endcase
    end

    // Registers; the tick is a one-cycle enable, never a clock.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pre_q      <= '0;
            ext_q      <= 3'h0;
            ext_lvl_q  <= 1'b0;
            timer_tick <= 1'b0;
        end
        else
        begin
            pre_q      <= pre_d;
            ext_q      <= ext_d;
            ext_lvl_q  <= ext_lvl_d;
            timer_tick <= tick_d;
        end
    end
endmodule

// ---- hw/tcic_cap_filter.sv ----
`timescale 1ns/100ps
`include "tcic_params.svh"
// ----------------------------------------------------------------------------
// Capture input synchroniser, optional four-sample filter, edge detector
// ----------------------------------------------------------------------------
module tcic_cap_filter
    import tcic_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic trig_in,
    input  wire logic filter_en,
    input  wire logic edge_rising,
    input  wire logic detect_en,
    output logic      cap_event
);
    localparam int NS = `TCIC_FILT_SAMPLES;
    logic [2:0]    sync_q, sync_d;
    logic          lvl_q, lvl_d;
    logic [NS-2:0] win_q, win_d;
    logic          filt_q, filt_d;
    logic          prev_q, prev_d;
    logic          src;
    logic          all_hi;
    logic          all_lo;

    // Sync level follows once stages 2 and 3 agree; the filter runs on the system clock.
    always_comb
    begin
        sync_d = {sync_q[1:0], trig_in};
        lvl_d  = (sync_q[1] == sync_q[2]) ? sync_q[2] : lvl_q;
        win_d  = {win_q[NS-3:0], lvl_q};
        // The live level is the fourth sample; a fourth stored stage would add a cycle.
        all_hi = &{win_q, lvl_q};
        all_lo = ~|{win_q, lvl_q};
        filt_d = all_hi ? 1'b1 : (all_lo ? 1'b0 : filt_q);
        src    = filter_en ? filt_q : lvl_q;
        prev_d = src;
        cap_event = detect_en && (edge_rising ? (src & ~prev_q)
                                              : (~src & prev_q));
    end

    // State registers.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync_q <= 3'h0;
            lvl_q  <= 1'b0;
            win_q  <= '0;
            filt_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            sync_q <= sync_d;
            lvl_q  <= lvl_d;
            win_q  <= win_d;
            filt_q <= filt_d;
            prev_q <= prev_d;
        end
    end
endmodule

// ---- verif/tcic_cpu_model.sv ----
`timescale 1ns/100ps
`include "tcic_params.svh"
// ----------------------------------------------------------------------------
// Processor core model on the 8-bit bus
// ----------------------------------------------------------------------------
module tcic_cpu_model
(
    input  wire logic       core_clk,
    output logic      [2:0] bus_addr,
    output logic            bus_rd,
    output logic            bus_wr,
    output logic      [7:0] bus_wdata,
    input  wire logic [7:0] bus_rdata
);
    // Bus idles with both strobes low from time zero.
    initial
    begin
        bus_addr = 3'h0;
        bus_rd = 1'h0;
        bus_wr = 1'h0;
        bus_wdata = 8'h00;
    end
    // Released write data is inverted so stale bytes never look valid.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'h1;
        @(posedge core_clk);
        #1;
        bus_wr = 1'h0;
        bus_wdata = ~d;
    endtask
    // Read data is registered, so it is taken one edge after the strobe.
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk);
        #1;
        bus_addr = a;
        bus_rd = 1'h1;
        @(posedge core_clk);
        #1;
        bus_rd = 1'h0;
        d = bus_rdata;
    endtask
    // Word accesses keep the latch order: high first on write, low first on read.
    task automatic wr16(input logic [2:0] lo, input logic [15:0] v);
        wr(lo + 3'h1, v[15:8]);
        wr(lo, v[7:0]);
    endtask
    task automatic rd16(input logic [2:0] lo, output logic [15:0] v);
        rd(lo, v[7:0]);
        rd(lo + 3'h1, v[15:8]);
    endtask
endmodule

// ---- verif/timer16_counter_input_capture_tb_top.sv ----
`timescale 1ns/100ps
`include "tcic_params.svh"
// ----------------------------------------------------------------------------
// Bench for the counter and capture unit
// ----------------------------------------------------------------------------
module timer16_counter_input_capture_tb_top
    import tcic_pkg::*;
;
    logic       core_clk, sys_rst, bus_rd, bus_wr, capture_pin, comparator_output;
    logic       comparator_capture_select, external_count_pin, capture_irq_enable;
    logic       overflow_irq_enable, capture_irq_ack, overflow_irq_ack;
    logic       capture_irq, overflow_irq, count_floor;
    logic [2:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata;
    tcic_word_t counter_value, capture_value, rv;
    int         err_total, num_checks, cyc, d0, d1;
    tcic_top tcic_top_i (.core_clk(core_clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
        .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .capture_pin(capture_pin), .comparator_output(comparator_output),
        .comparator_capture_select(comparator_capture_select),
        .external_count_pin(external_count_pin), .capture_irq_enable(capture_irq_enable),
        .overflow_irq_enable(overflow_irq_enable), .capture_irq_ack(capture_irq_ack),
        .overflow_irq_ack(overflow_irq_ack), .capture_irq(capture_irq),
        .overflow_irq(overflow_irq), .count_floor(count_floor),
        .counter_value(counter_value), .capture_value(capture_value));
    tcic_cpu_model tcic_cpu_model_i (.core_clk(core_clk), .bus_addr(bus_addr),
        .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
    // Free-running 100 MHz clock.
    initial
    begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end
    // The ceiling is far above the few hundred cycles the tests need.
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            stop_test();
        end
    end
    task automatic check(input tcic_word_t seen, input tcic_word_t exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Counts cycles until the capture interrupt shows, giving up after 40.
    task automatic wait_cap(output int n);
        n = 0;
        while (capture_irq !== 1'h1 && n < 40)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
    endtask
    task automatic t_counter;
        tcic_cpu_model_i.wr16(`TCIC_ADDR_CNT_LO, 16'h1234);
        check(counter_value, 16'h1234);
        check(16'(count_floor), 16'h0000);
        repeat (5) @(posedge core_clk);
        check(counter_value, 16'h1234);
        tcic_cpu_model_i.wr(`TCIC_ADDR_CNT_HI, 8'hab);
        check(counter_value, 16'h1234);
        tcic_cpu_model_i.rd16(`TCIC_ADDR_CNT_LO, rv);
        check(rv, 16'h1234);
        tcic_cpu_model_i.wr(`TCIC_ADDR_CTRL_B, 8'h01);
        tcic_cpu_model_i.wr16(`TCIC_ADDR_CNT_LO, 16'h0100);
        check(counter_value, 16'h0100);
        repeat (4) @(posedge core_clk);
        #1;
        check(counter_value, 16'h0104);
        overflow_irq_enable = 1'h1;
        tcic_cpu_model_i.wr16(`TCIC_ADDR_CNT_LO, 16'hfffe);
        repeat (6) @(posedge core_clk);
        #1;
        check(16'(overflow_irq), 16'h0001);
        overflow_irq_ack = 1'h1;
        @(posedge core_clk);
        #1;
        overflow_irq_ack = 1'h0;
        check(16'(overflow_irq), 16'h0000);
        // Dual slope with an 8-bit ceiling: reflect at the top, overflow at the floor.
        tcic_cpu_model_i.wr(`TCIC_ADDR_CTRL_A, 8'h01);
        tcic_cpu_model_i.wr16(`TCIC_ADDR_CNT_LO, 16'h00fd);
        repeat (4) @(posedge core_clk);
        #1;
        check(counter_value, 16'h00fd);
        tcic_cpu_model_i.wr16(`TCIC_ADDR_CNT_LO, 16'h0002);
        repeat (2) @(posedge core_clk);
        #1;
        check(16'(count_floor), 16'h0001);
        check(16'(overflow_irq), 16'h0000);
        @(posedge core_clk);
        #1;
        check(16'(overflow_irq), 16'h0001);
        tcic_cpu_model_i.wr(`TCIC_ADDR_CTRL_A, 8'h00);
        tcic_cpu_model_i.wr(`TCIC_ADDR_CTRL_B, 8'h00);
        $display("test counter done");
    endtask
    task automatic t_capture;
        capture_irq_enable = 1'h1;
        tcic_cpu_model_i.wr16(`TCIC_ADDR_CNT_LO, 16'h4321);
        tcic_cpu_model_i.wr(`TCIC_ADDR_CTRL_B, 8'h40);
        tcic_cpu_model_i.wr(`TCIC_ADDR_FLAGS, 8'h21);
        capture_pin = 1'h1;
        wait_cap(d0);
        check(16'(capture_irq), 16'h0001);
        check(capture_value, 16'h4321);
        tcic_cpu_model_i.rd16(`TCIC_ADDR_CAP_LO, rv);
        check(rv, 16'h4321);
        capture_irq_ack = 1'h1;
        @(posedge core_clk);
        #1;
        capture_irq_ack = 1'h0;
        check(16'(capture_irq), 16'h0000);
        tcic_cpu_model_i.wr16(`TCIC_ADDR_CNT_LO, 16'h0055);
        comparator_capture_select = 1'h1;
        repeat (8) @(posedge core_clk);
        tcic_cpu_model_i.wr(`TCIC_ADDR_FLAGS, 8'h20);
        comparator_output = 1'h1;
        wait_cap(d1);
        check(capture_value, 16'h0055);
        tcic_cpu_model_i.wr(`TCIC_ADDR_CTRL_B, 8'h00);
        tcic_cpu_model_i.wr(`TCIC_ADDR_FLAGS, 8'h20);
        tcic_cpu_model_i.wr16(`TCIC_ADDR_CNT_LO, 16'h0077);
        comparator_output = 1'h0;
        wait_cap(d1);
        check(capture_value, 16'h0077);
        $display("test capture done");
    endtask
    task automatic t_filter;
        comparator_capture_select = 1'h0;
        tcic_cpu_model_i.wr(`TCIC_ADDR_CTRL_B, 8'h80);
        tcic_cpu_model_i.wr16(`TCIC_ADDR_CNT_LO, 16'h0099);
        repeat (8) @(posedge core_clk);
        tcic_cpu_model_i.wr(`TCIC_ADDR_FLAGS, 8'h20);
        capture_pin = 1'h0;
        repeat (3) @(posedge core_clk);
        #1;
        capture_pin = 1'h1;
        repeat (20) @(posedge core_clk);
        #1;
        check(16'(capture_irq), 16'h0000);
        capture_pin = 1'h0;
        wait_cap(d1);
        check(16'(d1), 16'(d0 + 4));
        tcic_cpu_model_i.wr16(`TCIC_ADDR_CAP_LO, 16'hbeef);
        check(capture_value, 16'h0099);
        tcic_cpu_model_i.wr(`TCIC_ADDR_CTRL_B, 8'h58);
        tcic_cpu_model_i.wr16(`TCIC_ADDR_CAP_LO, 16'h0123);
        check(capture_value, 16'h0123);
        capture_pin = 1'h1;
        repeat (20) @(posedge core_clk);
        check(capture_value, 16'h0123);
        $display("test filter done");
    endtask
    // Main sequence: reset for five cycles, then the scenarios in turn.
    initial
    begin
        {sys_rst, capture_pin, comparator_output, comparator_capture_select} = 4'h8;
        {external_count_pin, capture_irq_enable, overflow_irq_enable} = 3'h0;
        {capture_irq_ack, overflow_irq_ack, err_total, num_checks, cyc} = '0;
        repeat (5) @(posedge core_clk);
        #1;
        sys_rst = 1'h0;
        check(counter_value, 16'h0000);
        check(16'(count_floor), 16'h0001);
        t_counter();
        t_capture();
        t_filter();
        stop_test();
    end
endmodule
